/* File: verif/adc_dma_sva.sv */
// adc_dma_sva: port-level assertions for the two-channel dma block
// assumes it is bound onto adc_dma and that clk_en is mostly high
`timescale 1ns/10ps
module adc_dma_sva
   import adc_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        nrst,
   input wire logic        clk_en,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [1:0]  master_abort,
   input wire logic [63:0] first_addr,
   input wire logic [1:0]  desc_req,
   input wire logic [1:0]  load_first,
   input wire logic [1:0]  bus_req,
   input wire logic [9:0]  burst_len,
   input wire logic [1:0]  fifo_en,
   input wire logic [1:0]  big_endian
);
   // apb phases; a frozen clock enable holds back every write
   wire setup  = psel && !penable && clk_en;
   wire acc    = psel && penable && pready;
   wire wr     = acc && pwrite && clk_en;
   wire mapped = paddr inside {ADC_OFF_CTRL0, ADC_OFF_FIRST0,
                               ADC_OFF_CTRL1, ADC_OFF_FIRST1};
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   ready_wait_a: assert property (setup |=> pready)
      else $error("no ready one cycle after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   // read data is only loaded on reads, so a refused write leaves it
   unmapped_err_a: assert property (
      acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   mapped_ok_a: assert property (acc && mapped |-> !pslverr)
      else $error("mapped access refused");
   endian_bit_a: assert property (
      wr && paddr == ADC_OFF_CTRL0
      |=> big_endian[0] == $past(pwdata[ADC_B_ORDER]))
      else $error("byte order output not following register");
   first_ptr_a: assert property (
      wr && paddr == ADC_OFF_FIRST0
      |=> first_addr[31:0] == $past(pwdata) && $stable(first_addr[63:32]))
      else $error("first pointer write wrong");
   restart_stop_a: assert property (
      wr && paddr == ADC_OFF_CTRL0 && pwdata[ADC_B_RESTART]
      |=> !fifo_en[0] && !desc_req[0] && !bus_req[0])
      else $error("restart left channel active");
   abort_halt_a: assert property (
      master_abort[1] && clk_en
      |=> (!desc_req[1] && !bus_req[1]) [*4])
      else $error("abort did not halt channel");
   // the fetch request is registered from the fetch state, one cycle on
   first_load_a: assert property (
      $rose(load_first[0])
      |-> !desc_req[0] ##1 (desc_req[0] && !load_first[0]))
      else $error("first load not followed by one fetch request");
   burst_len_a: assert property (
      burst_len[9:5] == ADC_BURST && burst_len[4:0] <= ADC_BURST)
      else $error("burst length out of range");
endmodule

/* File: verif/adc_host_mem.sv */
// adc_host_mem: host memory side of one channel, answering fetches,
// moving dwords while the bus is requested and acking write-backs
// assumes the design drops a request within LAT cycles of its ack
`timescale 1ns/10ps
module adc_host_mem #(
   parameter int NDW = 8,
   parameter int LAT = 2
) (
   input  wire logic       core_clk,
   input  wire logic       nrst,
   input  wire logic       desc_req,
   input  wire logic       bus_req,
   input  wire logic       wback_req,
   input  wire logic       end_of_list,
   input  wire logic       abort_cmd,
   input  wire logic [4:0] lim,
   output logic            desc_ack,
   output logic            desc_eol,
   output logic            dword_moved,
   output logic            buf_done,
   output logic            wback_ack,
   output logic            master_abort
);
   logic [3:0] wait_q;
   logic [4:0] cnt_q;
   // answer LAT+1 cycles after a request is seen; eol is noise outside the ack cycle
   always_ff @(posedge core_clk) begin
      desc_ack     <= 1'b0;
      wback_ack    <= 1'b0;
      desc_eol     <= 1'($urandom);
      master_abort <= abort_cmd;
      if (!nrst || !(desc_req || wback_req)) begin
         wait_q <= 4'h0;
      end else if (wait_q == 4'(LAT)) begin
         wait_q    <= 4'h0;
         desc_ack  <= desc_req;
         desc_eol  <= end_of_list;
         wback_ack <= wback_req;
      end else begin
         wait_q <= wait_q + 4'h1;
      end
   end
   // one dword a cycle while granted, at most lim, buffer done once NDW are counted
   always_ff @(posedge core_clk) begin
      dword_moved <= 1'b0;
      buf_done    <= 1'b0;
      if (!nrst || desc_ack) begin
         cnt_q <= 5'h0;
      end else if (cnt_q == 5'(NDW)) begin
         buf_done <= 1'b1;
         cnt_q    <= cnt_q + 5'h1;
      end else if (bus_req && cnt_q < lim) begin
         dword_moved <= 1'b1;
         cnt_q       <= cnt_q + 5'h1;
      end
   end
endmodule

/* File: verif/tb_adc_dac_dma_channel_control.sv */
// tb_adc_dac_dma_channel_control: apb tests of both dma channels
// assumes one host memory model per channel, eight dwords a buffer
`timescale 1ns/10ps
bind adc_dma adc_dma_sva u_sva (.core_clk(core_clk), .nrst(nrst),
   .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .master_abort(master_abort),
   .first_addr(first_addr), .desc_req(desc_req),
   .load_first(load_first), .bus_req(bus_req), .burst_len(burst_len),
   .fifo_en(fifo_en), .big_endian(big_endian));
module tb_adc_dac_dma_channel_control;
   import adc_pkg::*;
   localparam logic [32:0] MC = 33'h1_ffff_07ff;
   localparam logic [32:0] MF = 33'h1_ffff_ffff;
   logic        core_clk, nrst, clk_en, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   logic [19:0] fifo_level;
   logic [9:0]  lim, burst_len;
   logic [63:0] first_addr;
   logic [1:0]  end_of_list, abrt, desc_req, load_first;
   logic [1:0]  bus_req, wback_req, fifo_en, bige;
   wire  [1:0]  dack, deol, dmov, bdone, wack, mab;
   logic [32:0] q_e[$], q_m[$], me, mm;
   int          mismatches, n_checks, cyc, n_lf, t;
   adc_dma dut (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fifo_level(fifo_level), .desc_ack(dack), .desc_eol(deol),
      .dword_moved(dmov), .buf_done(bdone), .wback_ack(wack),
      .master_abort(mab), .first_addr(first_addr), .desc_req(desc_req),
      .load_first(load_first), .bus_req(bus_req), .wback_req(wback_req),
      .burst_len(burst_len), .fifo_en(fifo_en), .big_endian(bige));
   // one host memory per channel, ADC on index 0, DAC on index 1
   for (genvar c = 0; c < 2; c++) begin : g_mem
      adc_host_mem u_mem (.core_clk(core_clk), .nrst(nrst),
         .desc_req(desc_req[c]), .bus_req(bus_req[c]),
         .wback_req(wback_req[c]), .end_of_list(end_of_list[c]), .abort_cmd(abrt[c]),
         .lim(lim[5*c+:5]), .desc_ack(dack[c]), .desc_eol(deol[c]),
         .dword_moved(dmov[c]), .buf_done(bdone[c]), .wback_ack(wack[c]),
         .master_abort(mab[c]));
   end
   task chk(input string n, input logic [32:0] e, input logic [32:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // setup cycle, then access held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [32:0] e, input logic [32:0] m);
      if (!w) begin
         q_e.push_back(e);
         q_m.push_back(m);
      end
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (!pready);
      psel    <= 1'b0;
      penable <= 1'b0;
      // one idle edge, so a following call never assigns psel twice
      @(posedge core_clk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0, 33'h0);
   endtask
   task rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
      apb(1'b0, a, 32'h0, e, m);
   endtask
   task both(input logic [31:0] d);
      wr(ADC_OFF_CTRL0, d);
      wr(ADC_OFF_CTRL1, d);
   endtask
   task lv(input int a, input int d, input logic [1:0] e);
      fifo_level <= {10'(d), 10'(a)};
      repeat (3) @(posedge core_clk);
      chk("bus_req", {31'h0, e}, {31'h0, bus_req});
   endtask
   // read data and refusal are compared against the oldest note
   always @(posedge core_clk)
      if (psel && penable && pready && !pwrite) begin
         me = q_e.pop_front();
         mm = q_m.pop_front();
         chk("prdata", me & mm, {pslverr, prdata} & mm);
      end
   // start-of-list pulses and the hang limit
   always @(posedge core_clk) begin
      n_lf = n_lf + 32'(load_first[0]);
      cyc++;
      if (cyc == 8000) begin
         mismatches++;
         end_sim;
      end
   end
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   initial begin
      {nrst, clk_en, psel, penable, pwrite, paddr, pwdata} = '0;
      {fifo_level, lim, end_of_list, abrt} = '0;
      void'($urandom(75));
      repeat (2) @(posedge core_clk);
      nrst   <= 1'b1;
      clk_en <= 1'b1;
      rd(ADC_OFF_CTRL0, 33'h100, MC);
      rd(ADC_OFF_CTRL1, 33'h100, MC);
      rd(ADC_OFF_FIRST1, 33'h0, MF);
      rd(8'h10, 33'h1_0000_0000, MF);
      $display("reset and map test done");
      both(32'h1);
      repeat (12) @(posedge core_clk);
      chk("fifo_en", 33'h3, {31'h0, fifo_en});
      for (int c = 0; c < 16; c++) begin
         t = (c == 0) ? 16 : c * 32;
         both(32'({c[3:0], 4'h1}));
         lv(t - 1, 512, 2'b00);
         lv(t + 1, t - 1, 2'b11);
         lv(t - 1, t + 1, 2'b11);
         lv(0, 512, 2'b00);
         both(32'({c[3:0], 4'h9}));
         lv(1, t + 1, 2'b01);
         lv(0, t - 1, 2'b10);
         lv(0, t, 2'b00);
      end
      both(32'h2);
      rd(ADC_OFF_CTRL0, 33'h100, 33'h1_ffff_05ff);
      $display("threshold and mode test done");
      r = $urandom;
      wr(ADC_OFF_FIRST0, r);
      rd(ADC_OFF_FIRST0, {1'b0, r}, MF);
      {lim, end_of_list} <= {10'h3, 2'b01};
      t = n_lf;
      fifo_level <= {10'h200, 10'h3ff};
      wr(ADC_OFF_CTRL0, 32'h1);
      repeat (20) @(posedge core_clk);
      rd(ADC_OFF_CTRL0, 33'h3_0001, 33'h1_ffff_0701);
      wr(ADC_OFF_CTRL0, 32'h0);
      lim <= 10'h8;
      repeat (12) @(posedge core_clk);
      rd(ADC_OFF_CTRL0, 33'h3_0200, 33'h1_ffff_0701);
      wr(ADC_OFF_CTRL0, 32'h1);
      repeat (30) @(posedge core_clk);
      rd(ADC_OFF_CTRL0, 33'h8_0300, 33'h1_ffff_0700);
      chk("first loads", 33'h1, 33'(n_lf - t));
      $display("descriptor life test done");
      lim <= 10'h0;
      wr(ADC_OFF_CTRL1, 32'h1);
      repeat (10) @(posedge core_clk);
      abrt <= 2'b10;
      @(posedge core_clk);
      abrt <= 2'b00;
      repeat (3) @(posedge core_clk);
      rd(ADC_OFF_CTRL1, 33'h500, 33'h1_0000_0500);
      wr(ADC_OFF_CTRL1, 32'h1);
      rd(ADC_OFF_CTRL1, 33'h500, 33'h1_0000_0500);
      both(32'h2);
      both(32'h2);
      rd(ADC_OFF_CTRL1, 33'h100, MC);
      $display("abort test done");
      for (int i = 0; i < 4; i++) begin
         r = $urandom;
         wr(ADC_OFF_CTRL0, {24'h0, r[7:2], 2'b00});
         wr(ADC_OFF_FIRST1, ~r);
         rd(ADC_OFF_CTRL0, {25'h1, r[7:2], 2'b00}, MC);
         rd(ADC_OFF_CTRL1, 33'h100, MC);
         rd(ADC_OFF_FIRST1, {1'b0, ~r}, MF);
         chk("endian", {32'h0, r[2]}, {32'h0, bige[0]});
         chk("fifo_en", 33'h0, {31'h0, fifo_en});
         chk("endian1", 33'h0, {32'h0, bige[1]});
      end
      $display("config test done");
      end_sim;
   end
endmodule

/* File: verilog/adc_chan.sv */
// adc_chan: one dma channel, registers plus descriptor sequencer
// assumes a descriptor/burst engine outside that answers fetch, xfer, wback
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps
module adc_chan #(
   parameter bit IS_DAC = 1'b0
) (
   input  wire logic                         core_clk,
   input  wire logic                         nrst,
   input  wire logic                         clk_en,
   input  wire logic                         wr_ctrl,
   input  wire logic                         wr_first,
   input  wire logic [31:0]                  wdata,
   input  wire logic [adc_pkg::ADC_LVL_W-1:0] fifo_level,
   input  wire logic                         desc_ack,
   input  wire logic                         desc_eol,
   input  wire logic                         dword_moved,
   input  wire logic                         buf_done,
   input  wire logic                         wback_ack,
   input  wire logic                         master_abort,
   output logic      [31:0]                  ctrl_rd,
   output logic      [31:0]                  first_q,
   output logic                              desc_req_q,
   output logic                              load_first_q,
   output logic                              bus_req_q,
   output logic                              wback_req_q,
   output logic      [4:0]                   burst_q,
   output logic                              fifo_en_q,
   output logic                              big_endian_q
);
   import adc_pkg::*;

   adc_state_t               st_q;
   logic                     run_q;
   logic                     policy_q;
   logic [3:0]               th_code_q;
   logic                     done_q;
   logic                     fault_q;
   logic [15:0]              cnt_q;
   logic                     started_q;
   logic                     eol_q;
   logic                     drain_q;
   logic [ADC_LVL_W-1:0]     th_w;
   logic                     restart;
   logic                     stop;
   logic                     want;

   assign restart = clk_en && wr_ctrl && wdata[ADC_B_RESTART];
   // an abort drops every request at once instead of one cycle late
   assign stop    = restart || master_abort;

   // threshold decode: code zero is the floor, else code times 32
   assign th_w = (th_code_q == 4'h0) ? ADC_TH_MIN :
                 ADC_LVL_W'({th_code_q, 5'h00});

   // software-written control bits; restart is not stored, self-clearing
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         run_q        <= 1'b0;
         policy_q     <= 1'b0;
         big_endian_q <= 1'b0;
         th_code_q    <= ADC_RST_TH;
      end else if (clk_en && wr_ctrl) begin
         run_q        <= wdata[ADC_B_RUN] && !wdata[ADC_B_RESTART];
         policy_q     <= wdata[ADC_B_POLICY];
         big_endian_q <= wdata[ADC_B_ORDER];
         th_code_q    <= wdata[ADC_B_TH_LO +: 4];
      end
   end

   // first descriptor pointer, plain storage for software
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         first_q <= ADC_RST_FIRST;
      end else if (clk_en && wr_first) begin
         first_q <= wdata;
      end
   end

   // descriptor sequencer; clearing run only pauses, position is kept
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         st_q      <= ADC_ST_IDLE;
         started_q <= 1'b0;
         eol_q     <= 1'b0;
      end else if (clk_en) begin
         if (restart) begin
            st_q      <= ADC_ST_IDLE;
            started_q <= 1'b0;
         end else if (master_abort && st_q != ADC_ST_IDLE) begin
            st_q <= ADC_ST_FAULT;
         end else begin
            case (st_q)
               ADC_ST_IDLE: begin
                  if (run_q && !started_q) begin
                     st_q      <= ADC_ST_FETCH;
                     started_q <= 1'b1;
                  end
               end
               ADC_ST_FETCH: begin
                  if (desc_ack) begin
                     st_q  <= ADC_ST_XFER;
                     eol_q <= desc_eol;
                  end
               end
               ADC_ST_XFER: begin
                  if (buf_done) begin
                     st_q <= ADC_ST_WBACK;
                  end
               end
               ADC_ST_WBACK: begin
                  if (wback_ack) begin
                     st_q <= eol_q ? ADC_ST_IDLE : ADC_ST_FETCH;
                  end
               end
               ADC_ST_FAULT: begin
                  st_q <= ADC_ST_FAULT; // only restart leaves here
               end
               default: begin
                  st_q <= ADC_ST_IDLE;
               end
            endcase
         end
      end
   end

   // fetch and write-back requests, held only while running
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         desc_req_q   <= 1'b0;
         load_first_q <= 1'b0;
         wback_req_q  <= 1'b0;
      end else if (clk_en) begin
         desc_req_q   <= st_q == ADC_ST_FETCH && run_q && !stop;
         load_first_q <= st_q == ADC_ST_IDLE && run_q && !started_q
                         && !restart;
         wback_req_q  <= st_q == ADC_ST_WBACK && run_q && !stop;
      end
   end

   // fifo policy hysteresis with the policy bit clear only: drain_q marks a transfer run in progress
   always_comb begin
      want = 1'b0;
      if (!IS_DAC) begin
         if (policy_q) begin
            want = fifo_level != '0;
         end else begin
            want = drain_q ? (fifo_level != '0)
                           : (fifo_level > th_w);
         end
      end else begin
         if (policy_q) begin
            want = drain_q ? (fifo_level < th_w)
                           : (fifo_level < th_w);
         end else begin
            want = drain_q ? (fifo_level < ADC_FIFO_FULL)
                           : (fifo_level < th_w);
         end
      end
   end

   // bus request only while a buffer is being served and run is set
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         drain_q   <= 1'b0;
         bus_req_q <= 1'b0;
         burst_q   <= ADC_BURST;
      end else if (clk_en) begin
         drain_q   <= want && st_q == ADC_ST_XFER && !restart;
         bus_req_q <= want && st_q == ADC_ST_XFER && run_q && !stop;
         // short tail bursts on the adc channel only when fewer than a full burst remain
         if (!IS_DAC && fifo_level < ADC_LVL_W'(ADC_BURST)) begin
            burst_q <= 5'(fifo_level);
         end else begin
            burst_q <= ADC_BURST;
         end
      end
   end

   // fifos are held inactive whenever no descriptor is loaded
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         fifo_en_q <= 1'b0;
      end else if (clk_en) begin
         fifo_en_q <= !restart && (st_q == ADC_ST_XFER
                      || st_q == ADC_ST_WBACK);
      end
   end

   // status flags; a hardware set wins over the restart clear
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         done_q  <= 1'b0;
         fault_q <= 1'b0;
         cnt_q   <= 16'h0000;
      end else if (clk_en) begin
         if (master_abort && st_q != ADC_ST_IDLE) begin
            fault_q <= 1'b1;
         end else if (restart) begin
            fault_q <= 1'b0;
         end
         if ((st_q == ADC_ST_WBACK && wback_ack && eol_q)
             || (wr_ctrl && !wdata[ADC_B_RUN] && run_q)) begin
            done_q <= 1'b1;
         end else if (restart || (run_q && st_q == ADC_ST_FETCH)) begin
            done_q <= 1'b0;
         end
         if (st_q == ADC_ST_XFER && dword_moved) begin
            cnt_q <= cnt_q + 16'h0001;
         end else if (restart || (st_q == ADC_ST_FETCH && desc_ack)) begin
            cnt_q <= 16'h0000;
         end
      end
   end

   // read view of the control/status word; reserved bits read zero
   always_comb begin
      ctrl_rd = 32'h0000_0000;
      ctrl_rd[ADC_B_CNT_LO +: 16] = cnt_q;
      ctrl_rd[ADC_B_FAULT]        = fault_q;
      ctrl_rd[ADC_B_DONE]         = done_q;
      ctrl_rd[ADC_B_IDLE]         = st_q == ADC_ST_IDLE
                                    || st_q == ADC_ST_FAULT;
      ctrl_rd[ADC_B_TH_LO +: 4]   = th_code_q;
      ctrl_rd[ADC_B_POLICY]       = policy_q;
      ctrl_rd[ADC_B_ORDER]        = big_endian_q;
      ctrl_rd[ADC_B_RUN]          = run_q;
   end
endmodule

/* File: verilog/adc_dma.sv */
// adc_dma: apb slave holding two independent dma channels
// assumes the descriptor/burst engine and fifos sit outside this block
`timescale 1ns/10ps

module adc_dma (
   input  wire logic                         core_clk,
   input  wire logic                         nrst,
   input  wire logic                         clk_en,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [7:0]                   paddr,
   input  wire logic [31:0]                  pwdata,
   output logic      [31:0]                  prdata,
   output logic                              pready,
   output logic                              pslverr,
   input  wire logic [2*adc_pkg::ADC_LVL_W-1:0] fifo_level,
   input  wire logic [1:0]                   desc_ack,
   input  wire logic [1:0]                   desc_eol,
   input  wire logic [1:0]                   dword_moved,
   input  wire logic [1:0]                   buf_done,
   input  wire logic [1:0]                   wback_ack,
   input  wire logic [1:0]                   master_abort,
   output logic      [63:0]                  first_addr,
   output logic      [1:0]                   desc_req,
   output logic      [1:0]                   load_first,
   output logic      [1:0]                   bus_req,
   output logic      [1:0]                   wback_req,
   output logic      [9:0]                   burst_len,
   output logic      [1:0]                   fifo_en,
   output logic      [1:0]                   big_endian
);
   import adc_pkg::*;

   logic [31:0] ctrl_rd [2];
   logic [31:0] first_w [2];
   logic        setup;
   logic        hit;

   // no wait states: setup then answer in the first access cycle
   assign setup = psel && !penable;
   assign hit   = paddr == ADC_OFF_CTRL0 || paddr == ADC_OFF_FIRST0
                  || paddr == ADC_OFF_CTRL1 || paddr == ADC_OFF_FIRST1;

   // two channels, ch0 adc and ch1 dac, each its own registers
   for (genvar c = 0; c < 2; c++) begin : g_ch
      logic wr_ctrl;
      logic wr_first;
      // writes take effect at the completing edge only
      assign wr_ctrl  = psel && penable && pready && pwrite
                        && paddr == (c == 0 ? ADC_OFF_CTRL0 : ADC_OFF_CTRL1);
      assign wr_first = psel && penable && pready && pwrite
                        && paddr == (c == 0 ? ADC_OFF_FIRST0 : ADC_OFF_FIRST1);
      adc_chan #(
         .IS_DAC       (c == 1)
      ) u_chan (
         .core_clk     (core_clk),
         .nrst         (nrst),
         .clk_en       (clk_en),
         .wr_ctrl      (wr_ctrl),
         .wr_first     (wr_first),
         .wdata        (pwdata),
         .fifo_level   (fifo_level[c*ADC_LVL_W +: ADC_LVL_W]),
         .desc_ack     (desc_ack[c]),
         .desc_eol     (desc_eol[c]),
         .dword_moved  (dword_moved[c]),
         .buf_done     (buf_done[c]),
         .wback_ack    (wback_ack[c]),
         .master_abort (master_abort[c]),
         .ctrl_rd      (ctrl_rd[c]),
         .first_q      (first_w[c]),
         .desc_req_q   (desc_req[c]),
         .load_first_q (load_first[c]),
         .bus_req_q    (bus_req[c]),
         .wback_req_q  (wback_req[c]),
         .burst_q      (burst_len[c*5 +: 5]),
         .fifo_en_q    (fifo_en[c]),
         .big_endian_q (big_endian[c])
      );
      assign first_addr[c*32 +: 32] = first_w[c];
   end

   // apb answer registered from the setup cycle; unmapped gives pslverr
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (clk_en) begin
         pready  <= setup;
         pslverr <= setup && !hit;
         if (setup && !pwrite) begin
            case (paddr)
               ADC_OFF_CTRL0:  prdata <= ctrl_rd[0];
               ADC_OFF_FIRST0: prdata <= first_w[0];
               ADC_OFF_CTRL1:  prdata <= ctrl_rd[1];
               ADC_OFF_FIRST1: prdata <= first_w[1];
               default:        prdata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule

/* File: verilog/adc_pkg.sv */
// adc_pkg: shared constants for the two-channel dma control block
// assumes an apb slave at 25 mhz with 32-bit data, one word per register
package adc_pkg;
   // register byte offsets (two words per channel)
   localparam logic [7:0]  ADC_OFF_CTRL0  = 8'h00;
   localparam logic [7:0]  ADC_OFF_FIRST0 = 8'h04;
   localparam logic [7:0]  ADC_OFF_CTRL1  = 8'h08;
   localparam logic [7:0]  ADC_OFF_FIRST1 = 8'h0c;
   // control/status field positions
   localparam int ADC_B_RUN     = 0;
   localparam int ADC_B_RESTART = 1;
   localparam int ADC_B_ORDER   = 2;
   localparam int ADC_B_POLICY  = 3;
   localparam int ADC_B_TH_LO   = 4;
   localparam int ADC_B_IDLE    = 8;
   localparam int ADC_B_DONE    = 9;
   localparam int ADC_B_FAULT   = 10;
   localparam int ADC_B_CNT_LO  = 16;
   // threshold encoding in dword entries
   localparam logic [9:0]  ADC_TH_MIN   = 10'h010;
   localparam int          ADC_TH_SHIFT = 5;
   // fifo level width and depth
   localparam int          ADC_LVL_W    = 10;
   localparam logic [9:0]  ADC_FIFO_FULL = 10'h200;
   // host bus burst length in dwords
   localparam logic [4:0]  ADC_BURST    = 5'h10;
   // reset values
   localparam logic [31:0] ADC_RST_FIRST = 32'h0000_0000;
   localparam logic [3:0]  ADC_RST_TH    = 4'h0;
   // sequencer states
   typedef enum logic [2:0] {
      ADC_ST_IDLE, ADC_ST_FETCH, ADC_ST_XFER, ADC_ST_WBACK, ADC_ST_FAULT
   } adc_state_t;
endpackage
